// [pkg/pcg_pkg.sv]
// ****************************************
// shared constants and types
// ****************************************
package pcg_pkg;
  localparam int NUM_CH  = 4;
  localparam int NUM_GEN = 2;
  localparam int CNT_W   = 16;
  localparam int PSC_W   = 8;
  localparam int DT_W    = 8;
  // capture control field positions, low half serves even channel
  localparam int CAP_EN_BIT  = 0;
  localparam int RISE_IE_BIT = 1;
  localparam int FALL_IE_BIT = 2;
  localparam int HALF_OFS    = 16;
  // divider select codes
  localparam logic [2:0] DIV_1  = 3'h0;
  localparam logic [2:0] DIV_2  = 3'h1;
  localparam logic [2:0] DIV_4  = 3'h2;
  localparam logic [2:0] DIV_8  = 3'h3;
  localparam logic [2:0] DIV_16 = 3'h4;
  // reset values
  localparam logic [CNT_W-1:0] RST_CNT  = 16'h0000;
  localparam logic [PSC_W-1:0] RST_PSC  = 8'h00;
  localparam logic [3:0]       RST_DIV  = 4'h0;
  localparam logic [DT_W-1:0]  RST_DEAD = 8'h00;

  typedef struct packed {
    logic [CNT_W-1:0] period_reload_value;
    logic [CNT_W-1:0] compare_value;
    logic             auto_reload;
    logic             run;
    logic             wave_irq_en;
  } pcg_chan_cfg_t;

  typedef struct packed {
    logic [PSC_W-1:0] prescale;
    logic [2:0]       div_sel;
    logic [DT_W-1:0]  dead_time;
    logic             deadtime_enable;
  } pcg_gen_cfg_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cmp;
    logic             active;
    logic             halted;
    logic             raw;
    logic             oe;
    logic             out;
    logic             wave_flag;
    logic             cap_flag;
    logic             irq_wave;
    logic             irq_cap;
    logic [CNT_W-1:0] rise;
    logic [CNT_W-1:0] fall;
    logic [2:0]       pin_sync;
  } pcg_chan_t;

  typedef struct packed {
    logic [PSC_W-1:0] psc;
    logic [3:0]       div;
  } pcg_gen_t;

  typedef struct packed {
    pcg_gen_t  [NUM_GEN-1:0] gen;
    pcg_chan_t [NUM_CH-1:0]  ch;
  } pcg_state_t;

  typedef struct packed {
    logic [DT_W-1:0] dcnt;
    logic            src_q;
    logic            pos;
    logic            neg;
  } pcg_dt_t;
endpackage : pcg_pkg

// [core/pcg_deadband.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// dead-time generator for one pair
// ****************************************
module pcg_deadband (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // control
  input  wire logic                      tick,
  input  wire logic                      enable,
  input  wire logic                      src,
  input  wire logic [pcg_pkg::DT_W-1:0]  dead_time,
  // pair outputs
  output logic                           pos,
  output logic                           neg
);
  pcg_pkg::pcg_dt_t s;
  pcg_pkg::pcg_dt_t next_s;

  // both low for dead time after each edge of the source
  always_comb begin
    next_s = s;
    if (!enable) begin
      next_s.dcnt  = pcg_pkg::RST_DEAD;
      next_s.src_q = src;
      next_s.pos   = 1'b0;
      next_s.neg   = 1'b0;
    end else if (src != s.src_q) begin
      next_s.src_q = src;
      if (dead_time != pcg_pkg::RST_DEAD) begin
        next_s.dcnt = dead_time;
        next_s.pos  = 1'b0;
        next_s.neg  = 1'b0;
      end else begin
        next_s.pos = src;
        next_s.neg = ~src;
      end
    end else if (s.dcnt != pcg_pkg::RST_DEAD) begin
      if (tick) begin
        next_s.dcnt = s.dcnt - 8'h01;
        // last tick of the hold releases the pair, so low lasts dead_time ticks
        if (s.dcnt == 8'h01) begin
          next_s.pos = s.src_q;
          next_s.neg = ~s.src_q;
        end
      end
    end else begin
      next_s.pos = s.src_q;
      next_s.neg = ~s.src_q;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pos = s.pos;
  assign neg = s.neg;

  a_pair_no_overlap: assert property (@(posedge core_clk) disable iff (rst) !(s.pos && s.neg))
    else $error("pair outputs high together");
  a_dead_low_hold: assert property (@(posedge core_clk) disable iff (rst)
    (enable && src != s.src_q && dead_time > 8'h01) |=> (!s.pos && !s.neg) [*2])
    else $error("dead time not held low");
endmodule : pcg_deadband
`default_nettype wire

// [core/pcg_group.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// four-channel wave generator with capture
// ****************************************
// Summary of operation
// - four outputs run alone or as two complementary pairs, 0-1 and 2-3
// - each generator ticks through 8-bit prescaler then divide 1,2,4,8,16
// - each generator has two 16-bit down-counters and two comparators
// - counter reaching zero sets flag; request only when its enable set
// - auto-reload mode reloads period at zero and keeps counting
// - one-shot mode halts at zero after one flag
// - pair enable makes channel pair follow the even channel's timer
// - period and compare take buffered values only at start, at zero or on a capture reload
// - output goes high when counter equals compare value
// - capture enable turns output pin into input on same timer
// - rising edge latches counter to rise latch, falling to fall latch
// - channel zero rise and fall interrupt enables are bits 1 and 2
// - channel one uses bits 17, 18; channels two, three second register
// - capture interrupt reloads that channel's counter at once
module pcg_group (
  // clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  // configuration
  input  wire pcg_pkg::pcg_chan_cfg_t [3:0]    ch_cfg,
  input  wire pcg_pkg::pcg_gen_cfg_t  [1:0]    gen_cfg,
  input  wire logic [31:0]                     capture_control_first,
  input  wire logic [31:0]                     capture_control_second,
  // flag clears, one pulse per written 1
  input  wire logic [3:0]                      wave_irq_clr,
  input  wire logic [3:0]                      cap_irq_clr,
  // pins
  input  wire logic [3:0]                      cap_pin_in,
  output logic [3:0]                           wave_out,
  output logic [3:0]                           wave_oe,
  // status
  output logic [3:0]                           wave_interrupt_indicator,
  output logic [3:0]                           capture_interrupt_flag,
  output logic [7:0]                           irq_req,
  output logic [3:0][15:0]                     rise_capture_latch,
  output logic [3:0][15:0]                     fall_capture_latch
);
  pcg_pkg::pcg_state_t s;
  pcg_pkg::pcg_state_t next_s;
  logic [1:0]          gen_tick;
  logic [3:0]          cap_en;
  logic [3:0]          rise_e;
  logic [3:0]          fall_e;
  logic [3:0]          cap_evt;
  logic [1:0]          db_pos;
  logic [1:0]          db_neg;

  // divider mask for select code
  function automatic logic [3:0] pcg_div_mask(input logic [2:0] sel);
    case (sel)
      pcg_pkg::DIV_1:  pcg_div_mask = 4'h0;
      pcg_pkg::DIV_2:  pcg_div_mask = 4'h1;
      pcg_pkg::DIV_4:  pcg_div_mask = 4'h3;
      pcg_pkg::DIV_8:  pcg_div_mask = 4'h7;
      default:         pcg_div_mask = 4'hF;
    endcase
  endfunction : pcg_div_mask

  // ****************************************
  // generator ticks and dead-time pairs
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_g
      // prescaler zero with divider at mask gives one tick
      assign gen_tick[g] = (s.gen[g].psc == pcg_pkg::RST_PSC) &&
        ((s.gen[g].div & pcg_div_mask(gen_cfg[g].div_sel)) ==
         pcg_div_mask(gen_cfg[g].div_sel));
      pcg_deadband u_db (
        .core_clk  (core_clk),
        .rst       (rst),
        .tick      (gen_tick[g]),
        .enable    (gen_cfg[g].deadtime_enable),
        .src       (s.ch[2*g].raw),
        .dead_time (gen_cfg[g].dead_time),
        .pos       (db_pos[g]),
        .neg       (db_neg[g])
      );
    end
  endgenerate

  // ****************************************
  // per-channel capture decode
  // ****************************************
  genvar n;
  generate
    for (n = 0; n < 4; n++) begin : gen_n
      localparam int B = (n % 2) * pcg_pkg::HALF_OFS;
      logic [31:0] ccr;
      assign ccr        = (n < 2) ? capture_control_first : capture_control_second;
      assign cap_en[n]  = ccr[B + pcg_pkg::CAP_EN_BIT];
      // edges seen between second sync stage and its delayed copy
      assign rise_e[n]  = cap_en[n] && s.ch[n].pin_sync[1] && !s.ch[n].pin_sync[2];
      assign fall_e[n]  = cap_en[n] && !s.ch[n].pin_sync[1] && s.ch[n].pin_sync[2];
      assign cap_evt[n] = (rise_e[n] && ccr[B + pcg_pkg::RISE_IE_BIT]) ||
                          (fall_e[n] && ccr[B + pcg_pkg::FALL_IE_BIT]);

      a_flag_on_zero: assert property (@(posedge core_clk) disable iff (rst)
        (ch_cfg[n].run && s.ch[n].active && gen_tick[n/2] && !s.ch[n].halted &&
         s.ch[n].cnt == 16'h0000 && !cap_evt[n]) |=> s.ch[n].wave_flag)
        else $error("zero did not set flag");
      a_irq_gated: assert property (@(posedge core_clk) disable iff (rst)
        !ch_cfg[n].wave_irq_en |=> !s.ch[n].irq_wave)
        else $error("request without enable");
      a_auto_reload: assert property (@(posedge core_clk) disable iff (rst)
        (ch_cfg[n].run && s.ch[n].active && gen_tick[n/2] && !s.ch[n].halted &&
         s.ch[n].cnt == 16'h0000 && !cap_evt[n] && ch_cfg[n].auto_reload) |=>
        (s.ch[n].cnt == $past(ch_cfg[n].period_reload_value) &&
         s.ch[n].cmp == $past(ch_cfg[n].compare_value) && !s.ch[n].raw))
        else $error("auto reload wrong");
      a_one_shot: assert property (@(posedge core_clk) disable iff (rst)
        (ch_cfg[n].run && s.ch[n].active && gen_tick[n/2] && !s.ch[n].halted &&
         s.ch[n].cnt == 16'h0000 && !cap_evt[n] && !ch_cfg[n].auto_reload) |=>
        (s.ch[n].halted && s.ch[n].cnt == 16'h0000))
        else $error("one-shot did not halt");
      a_high_match: assert property (@(posedge core_clk) disable iff (rst)
        (ch_cfg[n].run && s.ch[n].active && gen_tick[n/2] && !s.ch[n].halted &&
         s.ch[n].cnt != 16'h0000 && s.ch[n].cnt == s.ch[n].cmp && !cap_evt[n]) |=>
        s.ch[n].raw ##1 (s.ch[n].out || cap_en[n] || gen_cfg[n/2].deadtime_enable))
        else $error("match did not drive high");
      a_rise_latch: assert property (@(posedge core_clk) disable iff (rst)
        rise_e[n] |=> s.ch[n].rise == $past(s.ch[n].cnt))
        else $error("rise latch wrong");
      a_cap_reload: assert property (@(posedge core_clk) disable iff (rst)
        (ch_cfg[n].run && s.ch[n].active && cap_evt[n]) |=>
        (s.ch[n].cap_flag && s.ch[n].cnt == $past(ch_cfg[n].period_reload_value)))
        else $error("capture did not reload");
      a_pin_released: assert property (@(posedge core_clk) disable iff (rst)
        cap_en[n] |=> !s.ch[n].oe)
        else $error("capture pin still driven");
    end
  endgenerate

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_s = s;
    // prescaler and divider per generator
    for (int gi = 0; gi < 2; gi++) begin
      if (s.gen[gi].psc == pcg_pkg::RST_PSC) begin
        next_s.gen[gi].psc = gen_cfg[gi].prescale;
        next_s.gen[gi].div = s.gen[gi].div + 4'h1;
      end else begin
        next_s.gen[gi].psc = s.gen[gi].psc - 8'h01;
      end
    end
    for (int i = 0; i < 4; i++) begin
      next_s.ch[i].pin_sync = {s.ch[i].pin_sync[1], s.ch[i].pin_sync[0], cap_pin_in[i]};
      // counter and comparator
      if (!ch_cfg[i].run) begin
        next_s.ch[i].active = 1'b0;
        next_s.ch[i].halted = 1'b0;
        next_s.ch[i].raw    = 1'b0;
      end else if (!s.ch[i].active || cap_evt[i]) begin
        next_s.ch[i].active = 1'b1;
        next_s.ch[i].cnt    = ch_cfg[i].period_reload_value;
        next_s.ch[i].cmp    = ch_cfg[i].compare_value;
      end else if (gen_tick[i/2] && !s.ch[i].halted) begin
        if (s.ch[i].cnt == pcg_pkg::RST_CNT) begin
          next_s.ch[i].raw = 1'b0;
          if (ch_cfg[i].auto_reload) begin
            next_s.ch[i].cnt = ch_cfg[i].period_reload_value;
            next_s.ch[i].cmp = ch_cfg[i].compare_value;
          end else begin
            next_s.ch[i].halted = 1'b1;
          end
        end else begin
          next_s.ch[i].cnt = s.ch[i].cnt - 16'h0001;
          if (s.ch[i].cnt == s.ch[i].cmp) begin
            next_s.ch[i].raw = 1'b1;
          end
        end
      end
      // capture latches
      if (rise_e[i]) begin
        next_s.ch[i].rise = s.ch[i].cnt;
      end
      if (fall_e[i]) begin
        next_s.ch[i].fall = s.ch[i].cnt;
      end
      // sticky flags, a set beats a clear in the same cycle
      next_s.ch[i].wave_flag = (s.ch[i].wave_flag && !wave_irq_clr[i]) ||
        (ch_cfg[i].run && s.ch[i].active && !cap_evt[i] && gen_tick[i/2] &&
         !s.ch[i].halted && s.ch[i].cnt == pcg_pkg::RST_CNT);
      next_s.ch[i].cap_flag  = (s.ch[i].cap_flag && !cap_irq_clr[i]) || cap_evt[i];
      next_s.ch[i].irq_wave  = next_s.ch[i].wave_flag && ch_cfg[i].wave_irq_en;
      next_s.ch[i].irq_cap   = next_s.ch[i].cap_flag;
      // pin drive and pair selection
      next_s.ch[i].oe = !cap_en[i];
      if (cap_en[i]) begin
        next_s.ch[i].out = 1'b0;
      end else if (gen_cfg[i/2].deadtime_enable) begin
        next_s.ch[i].out = (i % 2 == 0) ? db_pos[i/2] : db_neg[i/2];
      end else begin
        next_s.ch[i].out = s.ch[i].raw;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs straight from state
  // ****************************************
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wave_out[i]                 = s.ch[i].out;
      wave_oe[i]                  = s.ch[i].oe;
      wave_interrupt_indicator[i] = s.ch[i].wave_flag;
      capture_interrupt_flag[i]   = s.ch[i].cap_flag;
      irq_req[i]                  = s.ch[i].irq_wave;
      irq_req[i+4]                = s.ch[i].irq_cap;
      rise_capture_latch[i]       = s.ch[i].rise;
      fall_capture_latch[i]       = s.ch[i].fall;
    end
  end
endmodule : pcg_group
`default_nettype wire

// [sim/pcg_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// loads and capture sources on the pins
// ****************************************
module pcg_pin_model (
  // clock
  input  wire logic       core_clk,
  // design side of the pins
  input  wire logic [3:0] wave_out,
  input  wire logic [3:0] wave_oe,
  // level asked for by the bench
  input  wire logic [3:0] src_level,
  // resolved pin levels
  output logic      [3:0] cap_pin_in
);
  logic [3:0] drv;

  // source moves only on an edge, then holds steady through service
  always_ff @(posedge core_clk) begin
    drv <= src_level;
  end

  // a pin driven by the design shows its level, else the source drives it
  assign cap_pin_in = (wave_oe & wave_out) | (~wave_oe & drv);
endmodule : pcg_pin_model
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// self-checking bench for the wave group
// ****************************************
module tb;
  logic                            core_clk = 1'b0;
  logic                            rst      = 1'b1;
  pcg_pkg::pcg_chan_cfg_t [3:0]    ch_cfg   = '0;
  pcg_pkg::pcg_gen_cfg_t  [1:0]    gen_cfg  = '0;
  logic [31:0]                     ccr_a    = 32'h0;
  logic [31:0]                     ccr_b    = 32'h0;
  logic [3:0]                      wclr     = 4'h0;
  logic [3:0]                      cclr     = 4'h0;
  logic [3:0]                      src      = 4'h0;
  logic [3:0]                      pin, wout, woe, wflag, cflag;
  logic [7:0]                      irq;
  logic [3:0][15:0]                rlat, flat;
  int                              num_errors = 0;
  int                              tests_run = 0;
  int                              cyc = 0;
  int                              n, t0, t1, t2, h0, h1, hb;
  int                              psc_t[6] = '{0, 0, 0, 0, 0, 2};
  int                              div_t[6] = '{0, 1, 2, 3, 4, 0};
  int                              exp_t[6] = '{4, 8, 16, 32, 64, 12};

  // clock and cycle count
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  pcg_group pcg_group_i (
    .core_clk(core_clk), .rst(rst), .ch_cfg(ch_cfg), .gen_cfg(gen_cfg),
    .capture_control_first(ccr_a), .capture_control_second(ccr_b),
    .wave_irq_clr(wclr), .cap_irq_clr(cclr), .cap_pin_in(pin),
    .wave_out(wout), .wave_oe(woe), .wave_interrupt_indicator(wflag),
    .capture_interrupt_flag(cflag), .irq_req(irq),
    .rise_capture_latch(rlat), .fall_capture_latch(flat)
  );

  pcg_pin_model pcg_pin_model_i (
    .core_clk(core_clk), .wave_out(wout), .wave_oe(woe), .src_level(src), .cap_pin_in(pin)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic pcg_pkg::pcg_chan_cfg_t mk(input int p, input int c, input logic a,
                                                 input logic r, input logic e);
    mk = '{period_reload_value: p[15:0], compare_value: c[15:0], auto_reload: a, run: r,
           wave_irq_en: e};
  endfunction : mk

  function automatic pcg_pkg::pcg_gen_cfg_t mkg(input int p, input int d, input int t,
                                                 input logic e);
    mkg = '{prescale: p[7:0], div_sel: d[2:0], dead_time: t[7:0], deadtime_enable: e};
  endfunction : mkg

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // wait for a wave or capture flag, n reaches lim on a miss
  task automatic wait_bit(input logic is_cap, input int c, input int lim, output int k);
    k = 0;
    #1;
    while ((is_cap ? cflag[c] : wflag[c]) !== 1'b1 && k < lim) begin
      step();
      k++;
    end
  endtask : wait_bit

  // one-cycle write-one clear pulse
  task automatic clr(input logic is_cap, input int c);
    @(posedge core_clk);
    if (is_cap) cclr[c] <= 1'b1;
    else wclr[c] <= 1'b1;
    @(posedge core_clk);
    cclr <= 4'h0;
    wclr <= 4'h0;
    #1;
  endtask : clr

  // clear the set flag and return the cycle of the next one
  task automatic next_flag(input int c, output int t);
    clr(1'b0, c);
    wait_bit(1'b0, c, 200, n);
    t = cyc;
  endtask : next_flag

  // count high cycles of outputs 0 and 1 over 64 cycles
  task automatic count64();
    h0 = 0;
    h1 = 0;
    hb = 0;
    repeat (64) begin
      step();
      h0 += int'(wout[0] === 1'b1);
      h1 += int'(wout[1] === 1'b1);
      hb += int'(wout[0] === 1'b1 && wout[1] === 1'b1);
    end
  endtask : count64

  task automatic results();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    results();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    step();
    chk("outputs after reset", 32'h0, {wout, wflag, cflag, irq});
    // timer, auto-reload and double buffering
    @(posedge core_clk) ch_cfg[0] <= mk(3, 1, 1'b1, 1'b1, 1'b1);
    wait_bit(1'b0, 0, 20, n);
    chk("wave flag 0 set", 32'h1, 32'(n < 20));
    chk("irq 0", 32'h1, 32'(irq[0]));
    t0 = cyc;
    @(posedge core_clk) ch_cfg[0] <= mk(5, 1, 1'b1, 1'b1, 1'b1);
    next_flag(0, t1);
    next_flag(0, t2);
    chk("old period kept", 32'h4, 32'(t1 - t0));
    chk("new period", 32'h6, 32'(t2 - t1));
    // prescaler and divider table
    for (int k = 0; k < 6; k++) begin
      @(posedge core_clk);
      gen_cfg[0] <= mkg(psc_t[k], div_t[k], 0, 1'b0);
      ch_cfg[0]  <= mk(3, 1, 1'b1, 1'b1, 1'b1);
      wait_bit(1'b0, 0, 200, n);
      next_flag(0, t0);
      next_flag(0, t1);
      next_flag(0, t2);
      chk("tick interval", 32'(exp_t[k]), 32'(t2 - t1));
    end
    // pulse width in independent mode
    @(posedge core_clk);
    gen_cfg[0] <= mkg(0, 0, 0, 1'b0);
    ch_cfg[0]  <= mk(7, 3, 1'b1, 1'b1, 1'b0);
    repeat (20) step();
    count64();
    chk("high width", 32'd24, 32'(h0));
    // complementary pair with dead time
    @(posedge core_clk) gen_cfg[0] <= mkg(0, 0, 2, 1'b1);
    repeat (20) step();
    count64();
    chk("both high", 32'h0, 32'(hb));
    chk("pair first high", 32'd8, 32'(h0));
    chk("pair second high", 32'd24, 32'(h1));
    // one-shot on the second generator, request disabled
    @(posedge core_clk);
    ch_cfg[2] <= mk(4, 2, 1'b0, 1'b1, 1'b0);
    // stop channel 0 so its pin is low long before capture takes it over
    ch_cfg[0] <= '0;
    wait_bit(1'b0, 2, 20, n);
    chk("one-shot flag", 32'h1, 32'(n < 20));
    chk("irq 2 masked", 32'h0, 32'(irq[2]));
    clr(1'b0, 2);
    h0 = 0;
    repeat (30) begin
      step();
      h0 += int'(wflag[2] !== 1'b0 || wout[2] !== 1'b0);
    end
    chk("one-shot halted", 32'h0, 32'(h0));
    // capture on each channel, fall request only on even channels
    @(posedge core_clk);
    gen_cfg[0] <= mkg(0, 0, 0, 1'b0);
    // a halted one-shot only restarts after run drops
    ch_cfg[2]  <= '0;
    for (int c = 0; c < 4; c++) begin
      @(posedge core_clk);
      ch_cfg[c] <= mk(1000, 0, 1'b1, 1'b1, 1'b0);
      if (c < 2) ccr_a <= ccr_a | (32'((c % 2 == 0) ? 7 : 3) << (16 * (c % 2)));
      else ccr_b <= ccr_b | (32'((c % 2 == 0) ? 7 : 3) << (16 * (c % 2)));
      step();
      step();
      chk("pin turned input", 32'h0, 32'(woe[c]));
      @(posedge core_clk) src[c] <= 1'b1;
      wait_bit(1'b1, c, 10, n);
      chk("rise capture flag", 32'h1, 32'(n < 10));
      chk("capture irq", 32'h1, 32'(irq[4 + c]));
      chk("rise latch range", 32'h1, 32'(rlat[c] <= 16'h03E8));
      clr(1'b1, c);
      repeat (12) step();
      @(posedge core_clk) src[c] <= 1'b0;
      repeat (8) step();
      chk("fall capture flag", 32'(c % 2 == 0), 32'(cflag[c]));
      chk("fall latch after reload", 32'h1, 32'(flat[c] >= 16'd975 && flat[c] <= 16'd990));
      clr(1'b1, c);
    end
    results();
  end
endmodule : tb
`default_nettype wire
